// file: rtl/stpatt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// apb controller driving the attenuator control pins
module stpatt_ctrl (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    stpatt_if.controller     pins
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // one-hot sequencer states
    typedef enum logic [4:0] {
        CT_IDLE  = 5'h01,   // waiting for a word
        CT_SETUP = 5'h02,   // lines set up, strobe low
        CT_SHIFT = 5'h04,   // serial clocking
        CT_PULSE = 5'h08,   // strobe high
        CT_GAP   = 5'h10    // spacing before the next change
    } stpatt_st_e;

    // every flop of the controller lives in this one struct
    typedef struct packed {
        stpatt_st_e  st;
        logic [5:0]  code;      // word last written by software
        logic [5:0]  sh;        // copy being shifted out, msb first
        logic [5:0]  last;      // last parallel word applied
        logic [1:0]  mode;
        logic        sel;       // serial select pin
        logic        clk_o;     // serial clock pin
        logic        data_o;
        logic        le_o;
        logic [5:0]  lines;
        logic [1:0]  preset;
        logic [2:0]  bits;      // bits left to send
        logic [3:0]  div;       // clock divider
        logic [11:0] gap;       // spacing counter
        logic        pend;      // word waiting
        logic [31:0] rdata;
    } stpatt_ctl_s;

    // the whole controller state, registered once per clock
    stpatt_ctl_s q;        // registered state
    stpatt_ctl_s d;        // next state
    logic        wr_acc;   // write access phase
    logic        rd_setup; // read setup phase
    logic        busy;     // a word is waiting or on its way out

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    // every access completes in its first access cycle, so the read
    // data must already sit in its flop when that cycle starts
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;    // zero wait states
    assign pslverr  = 1'b0;    // nothing is refused with an error
    assign prdata   = q.rdata; // registered during the setup cycle
    // software polls this instead of counting the spacing itself
    assign busy     = q.pend || (q.st != CT_IDLE);

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // pin outputs straight from flops, so the attenuator never sees
    // a combinational glitch on its strobe or select;
    // preset pins only matter while the attenuator powers up
    assign pins.serial_select          = q.sel;
    assign pins.link_clk               = q.clk_o;
    assign pins.serial_data            = q.data_o;
    assign pins.latch_strobe           = q.le_o;
    assign pins.attenuation_code_lines = q.lines;
    assign pins.preset_select_msb      = q.preset[1];
    assign pins.preset_select_lsb      = q.preset[0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdata = '0;
        // read mux; setup-phase data so the access edge sees it
        if (rd_setup) begin
            if (paddr == stpatt_pkg::REG_CTRL) begin
                // control word reads back as written
                d.rdata = {22'h0, q.preset, q.mode, q.code};
            end else if (paddr == stpatt_pkg::REG_STATUS) begin
                // last parallel code and busy flag
                d.rdata = {18'h0, q.last, 7'h0, busy};
            end
            // any other address reads as zero
        end
        // a write queues a new word, unless CT_IDLE takes the pending word that cycle; busy software may overwrite it;
        // writes to any other address are dropped
        if (wr_acc && paddr == stpatt_pkg::REG_CTRL) begin
            d.code   = pwdata[5:0];
            d.mode   = pwdata[stpatt_pkg::CTRL_MODE_LO +: 2];
            d.preset = pwdata[stpatt_pkg::CTRL_PRESET_LO +: 2];
            d.pend   = 1'b1;
        end
        // --------------------------------------------------------
        // pin sequencing
        // --------------------------------------------------------
        case (q.st)
            CT_IDLE: begin
                if (q.pend && q.le_o && (q.mode != stpatt_pkg::MODE_DIRECT)) begin
                    // leaving direct mode: close the latch a cycle before the
                    // lines or the select move, so the old code is held cleanly
                    d.le_o = 1'b0;
                end else if (q.pend) begin
                    // take the pending word, one at a time
                    d.pend = 1'b0;
                    d.sel  = (q.mode == stpatt_pkg::MODE_SERIAL);
                    // direct: strobe stays high, the lines set the code at once
                    if (q.mode == stpatt_pkg::MODE_DIRECT) begin
                        d.le_o  = 1'b1;
                        d.lines = q.code;
                        d.last  = q.code;
                        d.gap   = stpatt_pkg::GAP_LOAD;
                        d.st    = CT_GAP;
                    end else if (q.mode == stpatt_pkg::MODE_SERIAL) begin
                        // first bit stands on the data pin before the first clock
                        d.le_o = 1'b0;
                        d.bits = stpatt_pkg::BITS_PER_WORD;
                        d.sh   = q.code;         // shift a copy, keep the register
                        d.data_o = q.code[5];
                        d.div  = stpatt_pkg::DIV_HALF;
                        d.st   = CT_SHIFT;
                    end else begin
                        // latched: lines move first, strobe still low
                        d.le_o  = 1'b0;
                        d.lines = q.code;
                        d.st    = CT_SETUP;
                    end
                end
            end
            CT_SETUP: begin
                // lines have stood a full cycle; open the latch
                d.le_o = 1'b1;
                d.st   = CT_PULSE;
            end
            CT_SHIFT: begin
                // each half period of the serial clock lasts DIV_HALF + 1 cycles
                if (q.div != 4'h0) begin
                    d.div = q.div - 4'h1;
                end else begin
                    d.div = stpatt_pkg::DIV_HALF;
                    d.clk_o = !q.clk_o;
                    if (q.clk_o) begin
                        // falling edge: next bit, msb first; data moves half a
                        // period ahead of the rising edge that samples it
                        d.sh   = {q.sh[4:0], 1'b0};
                        d.data_o = q.sh[4];
                        if (q.bits == 3'h1) begin
                            d.le_o = 1'b1;
                            d.st   = CT_PULSE;
                        end
                        d.bits = q.bits - 3'h1;
                    end
                end
            end
            CT_PULSE: begin
                // one cycle high is ample for the latch; close it and record;
                // status only reports parallel codes, serial words are not kept
                d.le_o = 1'b0;
                d.last = (q.sel) ? q.last : q.lines;
                d.gap  = stpatt_pkg::GAP_LOAD;
                d.st   = CT_GAP;
            end
            CT_GAP: begin
                // throttle to the internal generator's toggle rate;
                // software sees busy until the spacing has run out
                if (q.gap != 12'h0) begin
                    d.gap = q.gap - 12'h1;
                end else begin
                    d.st = CT_IDLE;
                end
            end
            // an illegal state code falls back to idle
            default: d.st = CT_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // one register for all state; reset puts every pin low, that is
    // parallel mode, strobe low and preset 00
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q    <= '0;
            q.st <= CT_IDLE;
        end else begin
            q <= d;
        end
    end

endmodule // stpatt_ctrl
`default_nettype wire

// file: rtl/stpatt_pkg.sv
// Behaviour
// - controller toggles state no faster than 25 kHz
// - six-bit code weights 16,8,4,2,1,0.5 dB
// - parallel power-up, strobe low: preset pins pick code
// - parallel power-up, strobe high: code from lines
// - select low parallel, high serial
// - latched parallel: change lines, then pulse strobe
// - strobe held high: code follows lines directly
// - parallel mode ignores serial data and clock
// - serial shift register shifts regardless of strobe
// - serial word sent and shifted MSB first
// - strobe high transparent, falling strobe holds code
// - controller loads bits with strobe low, then pulses
// - serial power-up takes code from parallel lines
// - serial data sampled on rising serial clock
`default_nettype none
package stpatt_pkg;

    // ------------------------------------------------------------
    // code layout
    // ------------------------------------------------------------
    localparam int unsigned CODE_W = 6;              // attenuation word width
    localparam int unsigned CNT_W  = 3;              // serial bit counter width
    localparam logic [2:0]  BITS_PER_WORD = 3'h6;    // serial bits per word

    // power-up preset codes in half-dB steps
    localparam logic [5:0] PRESET_REF  = 6'h00;      // reference state
    localparam logic [5:0] PRESET_8DB  = 6'h10;      // 8 dB
    localparam logic [5:0] PRESET_16DB = 6'h20;      // 16 dB
    localparam logic [5:0] PRESET_MAX  = 6'h3F;      // 31.5 dB

    // ------------------------------------------------------------
    // controller timing
    // ------------------------------------------------------------
    localparam int unsigned PCLK_HZ        = 10_000_000;
    localparam int unsigned TOGGLE_RATE_HZ = 25_000;   // fastest state change
    // least spacing between attenuation changes, rounded up
    localparam int unsigned TOGGLE_CYC =
        (PCLK_HZ + TOGGLE_RATE_HZ - 1) / TOGGLE_RATE_HZ;
    localparam int unsigned GAP_W = 12;              // spacing counter width
    localparam logic [11:0] GAP_LOAD = 12'(TOGGLE_CYC - 1);
    localparam logic [3:0]  DIV_HALF = 4'h2;         // serial clock half period - 1

    // ------------------------------------------------------------
    // apb register map of the controller
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL   = 12'h000;    // mode and code word
    localparam logic [11:0] REG_STATUS = 12'h004;    // busy and last code
    localparam int unsigned CTRL_MODE_LO = 6;        // bits 7:6 mode
    localparam int unsigned CTRL_PRESET_LO = 8;      // bits 9:8 preset select
    localparam int unsigned STAT_BUSY  = 0;          // status busy bit
    localparam int unsigned STAT_CODE_LO = 8;        // status code field

    // controller modes
    localparam logic [1:0] MODE_LATCHED = 2'h0;      // latched parallel
    localparam logic [1:0] MODE_DIRECT  = 2'h1;      // direct parallel
    localparam logic [1:0] MODE_SERIAL  = 2'h2;      // serial word

    // weight of code bit i in tenths of a dB
    function automatic int unsigned stpatt_weight_tenths(input int unsigned bit_idx);
        return 5 << bit_idx;
    endfunction

endpackage
`default_nettype wire

// file: rtl/stpatt_if.sv
`timescale 1ns/1ps
`default_nettype none
// pins between controller and attenuator control port
interface stpatt_if;
    logic                          link_clk;          // serial clock, from controller
    logic                          serial_data;       // serial data
    logic                          latch_strobe;      // latch strobe
    logic                          serial_select;     // low parallel, high serial
    logic [stpatt_pkg::CODE_W-1:0] attenuation_code_lines; // parallel lines
    logic                          preset_select_msb; // power-up preset msb
    logic                          preset_select_lsb; // power-up preset lsb

    modport device (
        input link_clk, serial_data, latch_strobe, serial_select,
              attenuation_code_lines, preset_select_msb, preset_select_lsb
    );
    modport controller (
        output link_clk, serial_data, latch_strobe, serial_select,
               attenuation_code_lines, preset_select_msb, preset_select_lsb
    );
endinterface
`default_nettype wire

// file: rtl/stpatt_device.sv
`timescale 1ns/1ps
`default_nettype none
// attenuator control port: keeps the attenuation state word
module stpatt_device (
    // power-up reset
    input  wire logic                          power_on_n,
    // pins
    stpatt_if.device                           pins,
    // attenuator drive
    output logic     [stpatt_pkg::CODE_W-1:0]  attenuation_state
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [stpatt_pkg::CODE_W-1:0] shift;   // serial shift register
    } stpatt_dev_s;

    stpatt_dev_s st_q;                           // shift register state
    stpatt_dev_s st_d;                           // its next value
    logic [stpatt_pkg::CODE_W-1:0] held_q;       // output latch contents
    logic                          pwr_up_q;     // still showing power-up code
    logic [stpatt_pkg::CODE_W-1:0] preset_code;  // decoded preset pins

    // preset pins pick one of four codes
    always_comb begin
        case ({pins.preset_select_msb, pins.preset_select_lsb})
            2'h0:    preset_code = stpatt_pkg::PRESET_REF;
            2'h1:    preset_code = stpatt_pkg::PRESET_8DB;
            2'h2:    preset_code = stpatt_pkg::PRESET_16DB;
            default: preset_code = stpatt_pkg::PRESET_MAX;
        endcase
    end

    // ------------------------------------------------------------
    // serial shift, msb first on rising serial clock
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // shifts whatever the strobe does; holds in parallel mode
        if (pins.serial_select) begin
            st_d.shift = {st_q.shift[stpatt_pkg::CODE_W-2:0], pins.serial_data};
        end
    end

    // serial clock only runs in serial mode; parallel ignores it
    always_ff @(posedge pins.link_clk or negedge power_on_n) begin
        if (!power_on_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // output latch: transparent while the strobe is high
    // ------------------------------------------------------------
    // modelled as a real latch since the part has no free clock
    always_latch begin
        if (!power_on_n) begin
            pwr_up_q <= 1'b1;
        end else if (pins.latch_strobe) begin
            pwr_up_q <= 1'b0;
        end
    end

    // the code latch itself; it closes on the strobe's falling level
    always_latch begin
        if (pins.latch_strobe) begin
            // serial: shift register through; parallel: lines through
            if (pins.serial_select) begin
                held_q <= st_q.shift;
            end else begin
                held_q <= pins.attenuation_code_lines;
            end
        end
    end

    // power-up code: serial takes lines, parallel low strobe takes preset
    always_comb begin
        if (pwr_up_q) begin
            if (pins.serial_select) begin
                attenuation_state = pins.attenuation_code_lines;
            end else begin
                attenuation_state = preset_code;
            end
        end else begin
            attenuation_state = held_q;
        end
    end

endmodule // stpatt_device
`default_nettype wire

// file: tb/stpatt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// pin-level checks on the link between controller and device
// ------------------------------------------------------------
module stpatt_monitor (
    // clock and resets
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       power_on_n,
    // link pins
    input wire logic       link_clk,
    input wire logic       serial_data,
    input wire logic       latch_strobe,
    input wire logic       serial_select,
    input wire logic [5:0] attenuation_code_lines,
    input wire logic       preset_select_msb,
    input wire logic       preset_select_lsb,
    // attenuator drive
    input wire logic [5:0] attenuation_state
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [5:0]  sh_q;    // shadow of the serial shift register
    logic        stb_q;   // strobe one cycle ago
    logic [5:0]  lines_q; // lines one cycle ago
    logic [11:0] gap_q;   // cycles since the last applied change, saturating
    logic        chg;     // a new state is applied in this cycle
    logic [5:0]  pre;     // code the preset pins pick at power-up

    // a change is a strobe rise, or new lines while the strobe stays high
    assign chg = latch_strobe && (!stb_q || (attenuation_code_lines != lines_q));

    // preset decode kept apart from the device so a swapped pair shows up
    always_comb begin
        case ({preset_select_msb, preset_select_lsb})
            2'h0:    pre = stpatt_pkg::PRESET_REF;
            2'h1:    pre = stpatt_pkg::PRESET_8DB;
            2'h2:    pre = stpatt_pkg::PRESET_16DB;
            default: pre = stpatt_pkg::PRESET_MAX;
        endcase
    end

    // shadow shift register, msb enters first and moves up
    always_ff @(posedge link_clk) begin
        if (serial_select) begin
            sh_q <= {sh_q[4:0], serial_data};
        end
    end

    // history and spacing counter; saturates so a long idle never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stb_q   <= 1'h0;
            lines_q <= 6'h00;
            gap_q   <= 12'hFFF;
        end else begin
            stb_q   <= latch_strobe;
            lines_q <= attenuation_code_lines;
            if (chg) begin
                gap_q <= 12'h000;
            end else if (gap_q != 12'hFFF) begin
                gap_q <= gap_q + 12'h001;
            end
        end
    end

    a_strobe_transparent: assert property (!serial_select && latch_strobe && power_on_n
        |-> attenuation_state == attenuation_code_lines) else $error("parallel state not lines");
    a_serial_latch: assert property (serial_select && latch_strobe && power_on_n
        |-> attenuation_state == sh_q) else $error("serial state not shifted word");
    a_hold_strobe_low: assert property (!latch_strobe && !stb_q && power_on_n && $past(power_on_n)
        && $stable(serial_select) && $stable(attenuation_code_lines)
        && $stable({preset_select_msb, preset_select_lsb})
        |-> $stable(attenuation_state)) else $error("state moved with strobe low");
    a_fall_holds: assert property ($fell(latch_strobe) && power_on_n && $past(power_on_n)
        && $stable(attenuation_code_lines)
        |-> attenuation_state == $past(attenuation_state)) else $error("falling strobe lost code");
    a_preset_power: assert property ($rose(power_on_n) && !serial_select && !latch_strobe
        |-> attenuation_state == pre) else $error("power-up preset wrong");
    a_serial_power: assert property ($rose(power_on_n) && serial_select
        |-> attenuation_state == attenuation_code_lines) else $error("serial power-up not lines");
    a_toggle_gap: assert property (chg
        |-> gap_q >= stpatt_pkg::GAP_LOAD) else $error("state changed too soon");
    a_shift_strobe_low: assert property (serial_select && $rose(link_clk)
        |-> !latch_strobe) else $error("shift with strobe high");
    a_pulse_one: assert property ($rose(latch_strobe) && serial_select
        |=> !latch_strobe) else $error("serial strobe pulse too long");
endmodule // stpatt_monitor
`default_nettype wire

// file: tb/stpatt_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); \
    end \
end
// ------------------------------------------------------------
// both ends joined; software side driven over apb
// ------------------------------------------------------------
module stpatt_tb;
    logic        pclk, presetn, power_on_n;  // clock and both resets
    logic        psel, penable, pwrite;      // apb request
    logic [11:0] paddr;                      // apb address
    logic [31:0] pwdata, prdata, rd;         // apb data
    logic        pready, pslverr;            // apb answer
    logic [5:0]  attenuation_state;          // device drive
    int          mismatches, cmp_count;      // report counters
    logic [5:0]  pre_exp [4] = '{6'h00, 6'h10, 6'h20, 6'h3F}; // preset codes
    logic [5:0]  codes [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F, 6'h2A};

    stpatt_if pins_if ();
    stpatt_ctrl stpatt_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins_if));
    stpatt_device stpatt_device_inst (.power_on_n(power_on_n), .pins(pins_if),
        .attenuation_state(attenuation_state));
    stpatt_monitor stpatt_monitor_inst (.pclk(pclk), .presetn(presetn),
        .power_on_n(power_on_n), .link_clk(pins_if.link_clk),
        .serial_data(pins_if.serial_data), .latch_strobe(pins_if.latch_strobe),
        .serial_select(pins_if.serial_select),
        .attenuation_code_lines(pins_if.attenuation_code_lines),
        .preset_select_msb(pins_if.preset_select_msb),
        .preset_select_lsb(pins_if.preset_select_lsb),
        .attenuation_state(attenuation_state));

    // 10 MHz bus clock
    always #50 pclk = ~pclk;

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 100);
        q = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            mismatches++;
            conclude();
        end
    endtask

    // write the control word, then poll status until the gap has run out
    task automatic wr_ctrl(input logic [1:0] mode, input logic [1:0] pre, input logic [5:0] code);
        logic [31:0] q;
        int          n;
        apb(1'h1, stpatt_pkg::REG_CTRL, {22'h0, pre, mode, code}, q);
        repeat (2) @(posedge pclk);
        n = 0;
        do begin
            apb(1'h0, stpatt_pkg::REG_STATUS, 32'h0, q);
            n++;
        end while (q[stpatt_pkg::STAT_BUSY] !== 1'h0 && n < 2000);
        if (n >= 2000) begin
            mismatches++;
            conclude();
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {pclk, presetn, power_on_n, psel, penable, pwrite} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        mismatches = 0;
        cmp_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        // the write lands while the device is held, so the preset decides
        for (int p = 0; p < 4; p++) begin
            power_on_n <= 1'h0;
            wr_ctrl(stpatt_pkg::MODE_LATCHED, 2'(p), 6'h15);
            power_on_n <= 1'h1;
            repeat (2) @(posedge pclk);
            `CHK(attenuation_state, pre_exp[p])
        end
        $display("test power-up presets done");
        foreach (codes[i]) begin
            wr_ctrl(stpatt_pkg::MODE_LATCHED, 2'h0, codes[i]);
            `CHK(attenuation_state, codes[i])
        end
        apb(1'h0, stpatt_pkg::REG_STATUS, 32'h0, rd);
        `CHK(rd, 32'h00002A00)
        $display("test latched parallel done");
        power_on_n <= 1'h0;
        // preset pins pick a code that the lines must override
        wr_ctrl(stpatt_pkg::MODE_DIRECT, 2'h3, 6'h35);
        power_on_n <= 1'h1;
        repeat (2) @(posedge pclk);
        `CHK(attenuation_state, 6'h35)
        wr_ctrl(stpatt_pkg::MODE_DIRECT, 2'h0, 6'h13);
        `CHK(attenuation_state, 6'h13)
        $display("test direct parallel done");
        wr_ctrl(stpatt_pkg::MODE_LATCHED, 2'h0, 6'h0C);
        `CHK(pins_if.serial_select, 1'h0)
        // serial word sent while held: lines, not the word, must win
        power_on_n <= 1'h0;
        wr_ctrl(stpatt_pkg::MODE_SERIAL, 2'h0, 6'h31);
        power_on_n <= 1'h1;
        repeat (40) @(posedge pclk);
        `CHK(attenuation_state, 6'h0C)
        foreach (codes[i]) begin
            wr_ctrl(stpatt_pkg::MODE_SERIAL, 2'h0, ~codes[i]);
            `CHK(attenuation_state, ~codes[i])
        end
        `CHK(pins_if.serial_select, 1'h1)
        // control word reads back intact after a serial send
        apb(1'h0, stpatt_pkg::REG_CTRL, 32'h0, rd);
        `CHK(rd, 32'h00000095)
        $display("test serial done");
        apb(1'h0, 12'h008, 32'h0, rd);
        `CHK(rd, 32'h0)
        `CHK(pslverr, 1'h0)
        $display("test unmapped read done");
        conclude();
    end
endmodule // stpatt_tb
`default_nettype wire
